// ### verilog/eac_pkg.sv
// Package for the external access control block: register map, fields, timing.
// Assumes a single 250 MHz CPU clock; one CPU clock period per ref_clk cycle.
package eac_pkg;
   // Register map
   localparam logic [7:0] EAC_CTRL_ADDR    = 8'h8E;
   localparam logic [7:0] EAC_STATUS_ADDR  = 8'h8F;
   localparam logic [7:0] EAC_CTRL_RESET   = 8'h0D;
   localparam logic [7:0] EAC_CTRL_WMASK   = 8'h7F;
   // Field positions
   localparam int FLD_LATCH_GATE  = 0;
   localparam int FLD_SPACE_SEL   = 1;
   localparam int FLD_SIZE_LO     = 2;
   localparam int FLD_SIZE_HI     = 3;
   localparam int FLD_HIGH_SUPP   = 4;
   localparam int FLD_STRETCH     = 5;
   localparam int FLD_WIDE        = 6;
   // Timing in CPU clock periods
   localparam logic [3:0] CYCLE_LEN      = 4'h6;
   localparam logic [3:0] STROBE_NORMAL  = 4'h3;
   localparam logic [3:0] STROBE_STRETCH = 4'hF;
   localparam logic [3:0] STROBE_START   = 4'h2;
   localparam logic [1:0] LATCH_DIV      = 2'h3;
   // Size encodings
   localparam logic [1:0] SIZE_256 = 2'h0;
   localparam logic [1:0] SIZE_512 = 2'h1;
   localparam logic [1:0] SIZE_1K  = 2'h2;
   localparam logic [1:0] SIZE_2K  = 2'h3;

   // Control fields as a struct
   typedef struct packed {
      logic       reserved;
      logic       wide_transfer_select;
      logic       strobe_stretch;
      logic       high_pointer_suppress;
      logic [1:0] internal_off_chip_data_ram_size_sel;
      logic       external_space_select;
      logic       latch_pulse_gate;
   } eac_ctrl_t;

   // One access request from the core
   typedef struct packed {
      logic        is_write;
      logic        pointer_mode;
      logic [15:0] addr;
      logic [15:0] wdata;
   } eac_req_t;
endpackage

// ### verilog/eac_ram.sv
// Small on-chip expanded RAM, 2K bytes, registered read data.
// Assumes address checked for size by the caller.
`timescale 1ns/100ps
module eac_ram (
   // Clock
   input  wire logic        ref_clk,
   // Access
   input  wire logic        we,
   input  wire logic [10:0] addr,
   input  wire logic [7:0]  wdata,
   output logic      [7:0]  rdata
);
   logic [7:0] mem [0:2047];

   // Write and registered read
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

// ### verilog/eac_top.sv
// External access control block: control register and external bus sequencer.
// Assumes the core issues one access at a time and waits for done.
// Operation
// RL1 - Wide select gives 16-bit moves, cleared gives 8-bit moves
// RL2 - Stretch set holds read or write strobe active 15 CPU clocks
// RL3 - Stretch cleared drives strobe for 3 CPU clocks
// RL4 - Suppress set keeps upper port on its own latch for pointer moves
// RL5 - Suppress cleared puts pointer high byte on upper port
// RL6 - Space select set targets off-chip RAM, cleared the on-chip RAM
// RL7 - Latch gate set pulses latch strobe only on moves, else clock/3
// RL8 - Two-bit size field sits in bits 3 down to 2
// RL9 - Bit 7 reserved, reads any value, software never writes one
// RL10 - Reset value is X000 1101 binary
// RL11 - Size codes map 256, 512, 1K, 2K bytes from address zero
// RL12 - Each external read or write cycle lasts six CPU clocks unstretched
// RL13 - Muxed port carries low address then data; upper port high byte
// RL14 - Control writes apply from next move; running access unchanged; the latch gate bit is used live from ctrl_r, not snapshotted
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
module eac_top (
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   // Register port
   input  wire logic [7:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [7:0]           reg_rdata,
   // Core access port
   input  wire logic                 req_valid,
   input  wire eac_pkg::eac_req_t    req,
   input  wire logic [7:0]           port_latch,
   output logic                      req_done,
   output logic      [15:0]          req_rdata,
   // External bus pins
   input  wire logic [7:0]           muxed_in,
   output logic      [7:0]           muxed_out,
   output logic                      muxed_oe,
   output logic      [7:0]           upper_address_port,
   output logic                      address_latch_strobe,
   output logic                      read_strobe_n,
   output logic                      write_strobe_n
);
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_STROBE, ST_TAIL, ST_ON_CHIP_EXPANDED_RAM, ST_DONE} eac_state_t;

   eac_pkg::eac_ctrl_t ctrl_r;
   eac_pkg::eac_ctrl_t act_r;
   eac_pkg::eac_req_t  cur_r;
   eac_state_t         state_r;
   logic [3:0]         cnt_r;
   logic               byte_r;
   logic [1:0]         div_r;
   logic [7:0]         pin_s1_r, pin_s2_r;
   logic [15:0]        rdata_r;
   logic [7:0]         ram_rdata;
   logic               ram_we;
   logic [15:0]        byte_addr;
   logic               to_on_chip_expanded_ram;

   // Last count of the two tail clocks: cycle less address clock, normal strobe and one
   localparam logic [3:0] TAIL_LAST = eac_pkg::CYCLE_LEN - eac_pkg::STROBE_NORMAL - 4'h2;

   // Size limit per field code
   function automatic logic [15:0] on_chip_expanded_ram_top(input logic [1:0] sel);
      case (sel)
         eac_pkg::SIZE_256: on_chip_expanded_ram_top = 16'h00FF;
         eac_pkg::SIZE_512: on_chip_expanded_ram_top = 16'h01FF;
         eac_pkg::SIZE_1K:  on_chip_expanded_ram_top = 16'h03FF;
         default:           on_chip_expanded_ram_top = 16'h07FF;
      endcase
   endfunction

   // Strobe width chosen by stretch bit
   function automatic logic [3:0] strobe_len(input logic stretch);
      strobe_len = stretch ? eac_pkg::STROBE_STRETCH : eac_pkg::STROBE_NORMAL;
   endfunction

   // Control register write, bit 7 held zero
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_r <= eac_pkg::EAC_CTRL_RESET; // RL10
      end else if (reg_wr && reg_addr == eac_pkg::EAC_CTRL_ADDR) begin
         ctrl_r <= reg_wdata & eac_pkg::EAC_CTRL_WMASK; // RL8 RL9
      end
   end

   // Register read, one cycle later
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            eac_pkg::EAC_CTRL_ADDR:   reg_rdata <= ctrl_r;
            eac_pkg::EAC_STATUS_ADDR: reg_rdata <= {5'h00, state_r};
            default:                  reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Pin input synchroniser
   always_ff @(posedge ref_clk) begin
      pin_s1_r <= muxed_in;
      pin_s2_r <= pin_s1_r;
   end

   assign byte_addr = cur_r.addr + {15'h0000, byte_r};
   assign to_on_chip_expanded_ram   = !act_r.external_space_select && (byte_addr <= on_chip_expanded_ram_top(act_r.internal_off_chip_data_ram_size_sel)); // RL6 RL11

   // Access sequencer, settings snapshot at start
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_r <= ST_IDLE;
         cnt_r   <= 4'h0;
         byte_r  <= 1'b0;
         act_r   <= eac_pkg::EAC_CTRL_RESET;
         cur_r   <= '0;
         rdata_r <= 16'h0000;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (req_valid) begin
                  act_r   <= ctrl_r; // RL14
                  cur_r   <= req;
                  byte_r  <= 1'b0;
                  cnt_r   <= 4'h0;
                  state_r <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               cnt_r <= 4'h0;
               if (to_on_chip_expanded_ram) begin
                  state_r <= ST_ON_CHIP_EXPANDED_RAM;
               end else begin
                  state_r <= ST_STROBE;
               end
            end
            ST_ON_CHIP_EXPANDED_RAM: begin
               // Registered RAM data valid one cycle on
               if (cnt_r == 4'h1) begin
                  if (byte_r) rdata_r[15:8] <= ram_rdata;
                  else rdata_r[7:0] <= ram_rdata;
                  state_r <= ST_TAIL;
                  cnt_r   <= 4'h0;
               end else begin
                  cnt_r <= cnt_r + 4'h1;
               end
            end
            ST_STROBE: begin
               // Strobe active 3 or 15 clocks
               if (cnt_r == strobe_len(act_r.strobe_stretch) - 4'h1) begin // RL2 RL3
                  cnt_r   <= 4'h0;
                  state_r <= ST_TAIL;
               end else begin
                  cnt_r <= cnt_r + 4'h1;
               end
            end
            ST_TAIL: begin
               // Two tail clocks let read data cross the pin synchroniser; six clocks in all for an unstretched off-chip cycle
               if (cnt_r != TAIL_LAST) begin // RL12
                  cnt_r <= cnt_r + 4'h1;
               end else begin
                  if (!to_on_chip_expanded_ram && byte_r) begin
                     rdata_r[15:8] <= pin_s2_r;
                  end else if (!to_on_chip_expanded_ram) begin
                     rdata_r[7:0] <= pin_s2_r;
                  end
                  cnt_r <= 4'h0;
                  if (act_r.wide_transfer_select && !byte_r) begin // RL1
                     byte_r  <= 1'b1;
                     state_r <= ST_ADDR;
                  end else begin
                     state_r <= ST_DONE;
                  end
               end
            end
            ST_DONE: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   assign req_done  = (state_r == ST_DONE);
   assign req_rdata = rdata_r;
   assign ram_we    = (state_r == ST_ON_CHIP_EXPANDED_RAM) && (cnt_r == 4'h0) && cur_r.is_write;

   // Expanded RAM
   eac_ram u_ram (
      .ref_clk (ref_clk),
      .we      (ram_we),
      .addr    (byte_addr[10:0]),
      .wdata   (byte_r ? cur_r.wdata[15:8] : cur_r.wdata[7:0]),
      .rdata   (ram_rdata)
   );

   // Latch strobe divider, one third of CPU clock
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         div_r <= 2'h0;
      end else if (div_r == eac_pkg::LATCH_DIV - 2'h1) begin
         div_r <= 2'h0;
      end else begin
         div_r <= div_r + 2'h1;
      end
   end

   // Bus pin outputs, registered
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         muxed_out            <= 8'h00;
         muxed_oe             <= 1'b0;
         upper_address_port   <= 8'h00;
         address_latch_strobe <= 1'b0;
         read_strobe_n        <= 1'b1;
         write_strobe_n       <= 1'b1;
      end else begin
         // Latch strobe: gated to moves or free running
         if (ctrl_r.latch_pulse_gate) begin
            address_latch_strobe <= (state_r == ST_ADDR) && !to_on_chip_expanded_ram; // RL7
         end else begin
            address_latch_strobe <= (div_r == 2'h0); // RL7
         end
         if (state_r == ST_ADDR && !to_on_chip_expanded_ram) begin
            muxed_out <= byte_addr[7:0]; // RL13
            muxed_oe  <= 1'b1;
            if (cur_r.pointer_mode && !act_r.high_pointer_suppress) begin
               upper_address_port <= byte_addr[15:8]; // RL5 RL13
            end else begin
               upper_address_port <= port_latch; // RL4
            end
         end else if (state_r == ST_STROBE) begin
            muxed_out <= byte_r ? cur_r.wdata[15:8] : cur_r.wdata[7:0];
            muxed_oe  <= cur_r.is_write;
         end else begin
            muxed_oe <= 1'b0;
         end
         // Strobes only in the strobe state, after the address phase
         read_strobe_n  <= !(state_r == ST_STROBE && !cur_r.is_write); // RL2 RL3
         write_strobe_n <= !(state_r == ST_STROBE && cur_r.is_write); // RL2 RL3
      end
   end

   // Assertions
   property strobe_width_p;
      @(posedge ref_clk) disable iff (reset)
      $fell(read_strobe_n && write_strobe_n) && !act_r.strobe_stretch
      |-> !(read_strobe_n && write_strobe_n) [*3] ##1 (read_strobe_n && write_strobe_n);
   endproperty
   strobe_normal_a: assert property (strobe_width_p) else $error("strobe not 3 clocks"); // RL3

   strobe_stretch_a: assert property (@(posedge ref_clk) disable iff (reset) // RL2
      $fell(read_strobe_n && write_strobe_n) && act_r.strobe_stretch
      |-> !(read_strobe_n && write_strobe_n) [*8] ##1 !(read_strobe_n && write_strobe_n) [*7]
      ##1 (read_strobe_n && write_strobe_n))
      else $error("stretched strobe not 15 clocks");

   reset_value_a: assert property (@(posedge ref_clk) $past(reset) |-> ctrl_r == eac_pkg::EAC_CTRL_RESET) // RL10
      else $error("control reset value wrong");

   reserved_zero_a: assert property (@(posedge ref_clk) disable iff (reset) !ctrl_r.reserved) // RL9
      else $error("reserved bit set");

   sequence start_s;
      state_r == ST_IDLE && req_valid;
   endsequence
   snapshot_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // RL14
      state_r != ST_IDLE && $past(state_r) != ST_IDLE |-> $stable(act_r))
      else $error("settings changed mid access");

   upper_port_a: assert property (@(posedge ref_clk) disable iff (reset) // RL5
      state_r == ST_ADDR && !to_on_chip_expanded_ram && cur_r.pointer_mode && !act_r.high_pointer_suppress
      |=> upper_address_port == $past(byte_addr[15:8]))
      else $error("upper port missing high byte");

   suppress_a: assert property (@(posedge ref_clk) disable iff (reset) // RL4
      state_r == ST_ADDR && !to_on_chip_expanded_ram && act_r.high_pointer_suppress
      |=> upper_address_port == $past(port_latch))
      else $error("upper port not own latch");

   latch_gate_a: assert property (@(posedge ref_clk) disable iff (reset) // RL7
      ctrl_r.latch_pulse_gate && $past(ctrl_r.latch_pulse_gate) && state_r == ST_IDLE && $past(state_r) == ST_IDLE
      |-> !address_latch_strobe)
      else $error("latch strobe outside move");

   on_chip_expanded_ram_route_a: assert property (@(posedge ref_clk) disable iff (reset) // RL6
      start_s ##1 (state_r == ST_ADDR && act_r.external_space_select) |=> state_r == ST_STROBE)
      else $error("off-chip select ignored");

   cycle_len_a: assert property (@(posedge ref_clk) disable iff (reset) // RL12
      state_r == ST_ADDR && !to_on_chip_expanded_ram && !act_r.strobe_stretch
      |-> ##6 (state_r == ST_ADDR || state_r == ST_DONE))
      else $error("bus cycle not six clocks");

   wide_split_a: assert property (@(posedge ref_clk) disable iff (reset) // RL1
      state_r == ST_TAIL && cnt_r == TAIL_LAST && !byte_r
      |=> (state_r == ST_ADDR) == act_r.wide_transfer_select)
      else $error("byte count wrong for width");

   addr_phase_a: assert property (@(posedge ref_clk) disable iff (reset) // RL13
      state_r == ST_ADDR && !to_on_chip_expanded_ram |=> muxed_oe && muxed_out == $past(byte_addr[7:0]))
      else $error("low address not on muxed port");

   on_chip_expanded_ram_size_a: assert property (@(posedge ref_clk) disable iff (reset) // RL11
      state_r == ST_ADDR && !act_r.external_space_select && byte_addr < 16'h0100
      |=> state_r == ST_ON_CHIP_EXPANDED_RAM)
      else $error("on-chip RAM missed for low address");
endmodule

// ### sim/eac_ext_mem.sv
// External byte memory on the multiplexed bus, for simulation only.
// Assumes the address is valid on the muxed port while the latch strobe is high.
`timescale 1ns/100ps
module eac_ext_mem #(
   parameter int LAG = 0
) (
   // Clock
   input  wire logic        ref_clk,
   // Bus pins from the block
   input  wire logic [7:0]  muxed_out,
   input  wire logic        muxed_oe,
   input  wire logic [7:0]  upper_address_port,
   input  wire logic        address_latch_strobe,
   input  wire logic        read_strobe_n,
   input  wire logic        write_strobe_n,
   // Bus pin back to the block, and the latched address for the testbench
   output logic      [7:0]  muxed_in,
   output logic      [15:0] seen_addr
);
   logic [7:0] mem [65536];
   int         lo_cyc = 0;
   initial muxed_in = 8'hA5;
   initial seen_addr = 16'h0000;
   // Address latch, write capture, strobe age
   always @(posedge ref_clk) begin
      if (address_latch_strobe && muxed_oe) seen_addr <= {upper_address_port, muxed_out};
      if (!write_strobe_n && muxed_oe) mem[seen_addr] <= muxed_out;
      lo_cyc <= read_strobe_n ? 0 : lo_cyc + 1;
   end
   // Read data after the lag, else a toggling released bus
   always @(posedge ref_clk)
      muxed_in <= (!read_strobe_n && lo_cyc >= LAG) ? mem[seen_addr] : ~muxed_in;
endmodule

// ### sim/eac_top_tb.sv
// Testbench for the external access control block.
// Assumes the block and the external memory model share one 250 MHz clock.
`timescale 1ns/100ps
module eac_top_tb;
   logic              ref_clk = 1'b0;
   logic              reset = 1'b1;
   logic [7:0]        reg_addr, reg_wdata, reg_rdata, port_latch, muxed_in, muxed_out, upper_address_port;
   logic              reg_wr, reg_rd, req_valid, req_done, muxed_oe, address_latch_strobe;
   logic              read_strobe_n, write_strobe_n;
   eac_pkg::eac_req_t req;
   logic [15:0]       req_rdata, seen_addr;
   int                fails = 0, n_checks = 0, lo_cnt = 0, last_w = 0, n_strb = 0, n_ale = 0, cyc = 0, s;

   eac_top eac_top_i (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req(req),
      .port_latch(port_latch), .req_done(req_done), .req_rdata(req_rdata), .muxed_in(muxed_in),
      .muxed_out(muxed_out), .muxed_oe(muxed_oe), .upper_address_port(upper_address_port),
      .address_latch_strobe(address_latch_strobe), .read_strobe_n(read_strobe_n),
      .write_strobe_n(write_strobe_n));
   eac_ext_mem eac_ext_mem_i (.ref_clk(ref_clk), .muxed_out(muxed_out), .muxed_oe(muxed_oe),
      .upper_address_port(upper_address_port), .address_latch_strobe(address_latch_strobe),
      .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .muxed_in(muxed_in),
      .seen_addr(seen_addr));

   always #2 ref_clk = ~ref_clk;

   task automatic test_done();
      if (fails == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic reg_w(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_r(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m, input string nm);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(nm, {8'h00, reg_rdata & m}, {8'h00, exp});
   endtask

   // One core access, held until done, then settle
   task automatic acc(input logic wr, input logic ptr, input logic [15:0] a, input logic [15:0] d);
      int n;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req <= {wr, ptr, a, d};
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (req_done !== 1'b1 && n < 200);
      req_valid <= 1'b0;
      if (n >= 200) fails++;
      repeat (2) @(posedge ref_clk);
   endtask

   // Strobe width, strobe count, latch pulses, hang limit
   always @(posedge ref_clk) begin
      if (!read_strobe_n || !write_strobe_n) lo_cnt <= lo_cnt + 1;
      else if (lo_cnt != 0) begin
         last_w <= lo_cnt;
         n_strb <= n_strb + 1;
         lo_cnt <= 0;
      end
      if (address_latch_strobe) n_ale <= n_ale + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         test_done();
      end
   end

   // Main sequence
   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd, req_valid, req} = '0;
      port_latch = 8'h5A;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      reg_r(8'h8E, 8'h0D, 8'h7F, "ctrl reset");
      reg_w(8'h8E, 8'h0E);
      reg_r(8'h8E, 8'h0E, 8'h7F, "ctrl fields");
      reg_r(8'h10, 8'h00, 8'hFF, "unmapped");
      s = n_ale;
      repeat (30) @(posedge ref_clk);
      #1 chk("free latch", 16'(n_ale - s), 16'd10);
      reg_w(8'h8E, 8'h0F);
      repeat (2) @(posedge ref_clk);
      s = n_ale;
      repeat (30) @(posedge ref_clk);
      #1 chk("gated latch", 16'(n_ale - s), 16'd0);
      // Off-chip byte moves, register and pointer forms
      s = n_strb;
      acc(1'b1, 1'b0, 16'h0034, 16'h00C3);
      chk("strobe count", 16'(n_strb - s), 16'd1);
      chk("short strobe", 16'(last_w), 16'd3);
      chk("reg addr", seen_addr, 16'h5A34);
      acc(1'b0, 1'b0, 16'h0034, 16'h0000);
      chk("byte read", {8'h00, req_rdata[7:0]}, 16'h00C3);
      acc(1'b1, 1'b1, 16'h1234, 16'h0096);
      chk("ptr addr", seen_addr, 16'h1234);
      reg_w(8'h8E, 8'h1F);
      acc(1'b1, 1'b1, 16'h1234, 16'h0011);
      chk("suppressed addr", seen_addr, 16'h5A34);
      reg_w(8'h8E, 8'h2F);
      acc(1'b0, 1'b0, 16'h0034, 16'h0000);
      chk("long strobe", 16'(last_w), 16'd15);
      chk("slow read", {8'h00, req_rdata[7:0]}, 16'h0011);
      fork
         acc(1'b0, 1'b0, 16'h0034, 16'h0000);
         begin
            repeat (5) @(posedge ref_clk);
            reg_w(8'h8E, 8'h0F);
         end
      join
      chk("running access", 16'(last_w), 16'd15);
      // Wide moves split into two bytes
      reg_w(8'h8E, 8'h4F);
      s = n_strb;
      acc(1'b1, 1'b0, 16'h0040, 16'hBEEF);
      chk("wide strobes", 16'(n_strb - s), 16'd2);
      chk("wide addr", seen_addr, 16'h5A41);
      acc(1'b0, 1'b0, 16'h0040, 16'h0000);
      chk("wide read", req_rdata, 16'hBEEF);
      chk("wide width", 16'(last_w), 16'd3);
      // On-chip RAM size boundaries
      for (int k = 0; k < 4; k++) begin
         reg_w(8'h8E, 8'(8'h01 | (k << 2)));
         s = n_strb;
         acc(1'b1, 1'b0, 16'((16'h0100 << k) - 1), 16'(8'hA0 + k));
         acc(1'b0, 1'b0, 16'((16'h0100 << k) - 1), 16'h0000);
         chk("ram read", {8'h00, req_rdata[7:0]}, 16'(8'hA0 + k));
         chk("ram silent", 16'(n_strb - s), 16'd0);
         acc(1'b0, 1'b0, 16'(16'h0100 << k), 16'h0000);
         chk("above ram", 16'(n_strb - s), 16'd1);
      end
      test_done();
   end
endmodule
